// >>> logic/eil_regs.svh
`ifndef EIL_REGS_SVH
`define EIL_REGS_SVH

// Register map (byte addresses on APB)
`define EIL_ADDR_STATUS_CONTROL 12'h000
`define EIL_ADDR_VECTOR         12'h004
`define EIL_ADDR_PIN_LEVEL      12'h008
`define EIL_ADDR_BITS           12

// Field positions of the status and control register
`define EIL_BIT_SENS    0
`define EIL_BIT_MASK    1
`define EIL_BIT_CLEAR   2
`define EIL_BIT_PENDING 3

// Reset values
`define EIL_SC_RESET    8'h00
`define EIL_VECTOR_RST  16'hFFFA

// Vector locations that the CPU reads when a request is taken
`define EIL_VEC_HI_LOC  16'hFFFA
`define EIL_VEC_LO_LOC  16'hFFFB

`endif

// >>> logic/eil_pkg.sv
package eil_pkg;

  // Sensitivity choices
  typedef enum logic
  {
    EIL_EDGE_ONLY,
    EIL_EDGE_LEVEL
  } eil_sens_t;

  // Control fields written by software
  typedef struct packed
  {
    logic      mask;
    eil_sens_t sens;
  } eil_ctrl_t;

  // CPU side signals grouped together
  typedef struct packed
  {
    logic        vec_fetch;
    logic        global_mask;
    logic        break_state;
    logic        break_clear_enable;
  } eil_cpu_t;

endpackage

// >>> logic/eil_pin_sync.sv
`timescale 1ns/1ps
`include "eil_regs.svh"

// Two stage synchroniser with falling edge detect on an active low pin
module eil_pin_sync
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin side
  input  wire logic pin_in,
  // Synchronised outputs
  output logic      level,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  // Marks which history flops hold a real pin sample rather than a reset value
  logic [2:0] seen_r;

  // Reset to idle-high; seen_r keeps a pin held low at reset from being seen as an edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      seen_r <= 3'h0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      seen_r <= {seen_r[1:0], 1'b1};
    end
  end

  assign level = sync_r;
  // High sample then low sample; a reset value never counts as the high sample,
  // so a pin held low through reset raises no edge after it
  assign fall  = seen_r[2] & prev_r & ~sync_r;

endmodule

// >>> logic/eil_top.sv
// Function
// - Low pin with trigger met sets latch
// - Vector fetch acknowledge clears causing latch
// - Writing one to clear bit clears latch
// - Reset clears latch and sensitivity bit
// - Sensitivity one edge+level, zero edge only
// - Edge mode latch holds until acknowledge
// - Edge mode acknowledge clears regardless of pin
// - Level mode needs acknowledge and pin high
// - Local mask blocks forwarding of request
// - Global CPU mask also blocks request
// - Edge after acknowledge latches new request
// - Taken request loads vector from two locations; the code drives vector_addr from an APB-written register instead
// - Pending flag reads latch, ignores mask
// - Clear bit write-only, reads zero
// - Mask bit read/write, reset clears it
// - Break clear allowed when enable set
// - Break clear ignored when enable zero
// - Pin level visible for branch instructions
`timescale 1ns/1ps
`include "eil_regs.svh"

module eil_top
(
  // APB clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // External pin, active low
  input  wire logic                 ext_int_pin_n,
  // CPU side
  input  wire eil_pkg::eil_cpu_t    cpu_in,
  output logic                      cpu_irq_req,
  output logic                      pin_level_for_branch,
  output logic [15:0]               vector_addr
);

  import eil_pkg::*;

  // Latch and control state
  logic                             latch_r;
  logic                             latch_nxt;
  eil_ctrl_t                        ctrl_r;
  logic                             ack_pend_r;
  logic                             ack_pend_nxt;
  logic                             irq_r;
  logic                             branch_r;
  logic [15:0]                      vec_r;
  logic [31:0]                      prdata_r;
  logic                             pslverr_r;
  logic                             pready_r;
  logic                             pin_level;
  logic                             pin_fall;

  // Synchroniser for the pin
  // sync and edge
  eil_pin_sync u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ext_int_pin_n),
    .level   (pin_level),
    .fall    (pin_fall)
  );

  // APB decode; every access completes in its first access cycle
  wire                              apb_acc    = psel & penable;
  wire                              apb_wr     = apb_acc & pwrite;
  wire                              apb_rd     = apb_acc & ~pwrite;
  wire [`EIL_ADDR_BITS-1:0]         addr_lo    = paddr[`EIL_ADDR_BITS-1:0];
  wire                              hit_sc     = (addr_lo == `EIL_ADDR_STATUS_CONTROL) && (paddr[31:12] == 20'h00000);
  wire                              hit_vec    = (addr_lo == `EIL_ADDR_VECTOR) && (paddr[31:12] == 20'h00000);
  wire                              hit_pin    = (addr_lo == `EIL_ADDR_PIN_LEVEL) && (paddr[31:12] == 20'h00000);
  wire                              hit_any    = hit_sc | hit_vec | hit_pin;
  wire                              wr_sc      = apb_wr & hit_sc & pstrb[0];

  // Software clear, gated in break state by the enable from the integration unit
  // write one clears
  wire                              sw_clear_req = wr_sc & pwdata[`EIL_BIT_CLEAR];
  wire                              sw_clear   = sw_clear_req &
                                                 (~cpu_in.break_state | cpu_in.break_clear_enable);

  wire                              ack_now    = sw_clear | (cpu_in.vec_fetch & latch_r);

  // Trigger condition
  // pin low sets
  wire                              level_mode = (ctrl_r.sens == EIL_EDGE_LEVEL);
  wire                              trig       = pin_fall | (level_mode & ~pin_level);

  // Acknowledge remembered in level mode until the pin goes high
  // ack plus pin high
  wire                              ack_seen   = ack_now | ack_pend_r;
  wire                              lvl_done   = ack_seen & pin_level;

  // Latch next state; a new edge wins over a clear in the same cycle
  always_comb
  begin
    latch_nxt    = latch_r;
    ack_pend_nxt = ack_pend_r;
    if (level_mode)
    begin
      if (lvl_done)
      begin
        latch_nxt    = 1'b0;
        ack_pend_nxt = 1'b0;
      end
      else if (ack_now && latch_r)
      begin
        ack_pend_nxt = 1'b1;
      end
    end
    else
    begin
      if (ack_now)
      begin
        latch_nxt = 1'b0;
      end
      ack_pend_nxt = 1'b0;
    end
    if (trig && !(level_mode && lvl_done && pin_level))
    begin
      latch_nxt = 1'b1;
    end
    if (pin_fall)
    begin
      latch_nxt = 1'b1;
    end
  end

  // Latch, acknowledge memory and control register
  // reset clears latch and mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_r    <= 1'b0;
      ack_pend_r <= 1'b0;
      ctrl_r     <= eil_ctrl_t'(2'b00);
    end
    else
    begin
      latch_r    <= latch_nxt;
      ack_pend_r <= ack_pend_nxt;
      if (wr_sc)
      begin
        ctrl_r.mask <= pwdata[`EIL_BIT_MASK];
        ctrl_r.sens <= eil_sens_t'(pwdata[`EIL_BIT_SENS]);
      end
    end
  end

  // Request forwarding and vector
  // local mask
  wire                              irq_nxt    = latch_nxt & ~ctrl_r.mask & ~cpu_in.global_mask;

  // Vector register; software may program the address stored at the vector locations
  wire [15:0]                       vec_nxt    = (apb_wr & hit_vec) ? pwdata[15:0] : vec_r;

  // Read mux
  // pending flag
  wire [31:0]                       sc_read    = {28'h0000000, latch_r, 1'b0, ctrl_r.mask, ctrl_r.sens};
  wire [31:0]                       rd_mux     = hit_sc  ? sc_read :
                                                 hit_vec ? {16'h0000, vec_r} :
                                                 hit_pin ? {31'h00000000, pin_level} : 32'h00000000;

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_r     <= 1'b0;
      branch_r  <= 1'b1;
      vec_r     <= `EIL_VECTOR_RST;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
      pready_r  <= 1'b0;
    end
    else
    begin
      irq_r     <= irq_nxt;
      branch_r  <= pin_level;
      vec_r     <= vec_nxt;
      pready_r  <= psel & ~penable;
      prdata_r  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr_r <= psel & ~penable & ~hit_any;
    end
  end

  // Unused read strobe kept for decode symmetry is folded into prdata timing
  assign pready               = pready_r;
  assign prdata               = prdata_r;
  assign pslverr              = pslverr_r;
  assign cpu_irq_req          = irq_r;
  assign pin_level_for_branch = branch_r;
  assign vector_addr          = vec_r;

endmodule

// >>> testbench/eil_top_asserts.sv
`timescale 1ns/1ps
module eil_top_asserts
(
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // Bus
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Pin and CPU side
  input wire logic              ext_int_pin_n,
  input wire eil_pkg::eil_cpu_t cpu_in,
  input wire logic              cpu_irq_req,
  input wire logic              pin_level_for_branch
);
  import eil_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Zero wait states, so ready follows setup and lasts one cycle
  setup_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
  // Global mask gates the request
  gmask_block_a: assert property (cpu_irq_req |-> !$past(cpu_in.global_mask)) else $error("irq masked");
  gmask_drop_a: assert property ($rose(cpu_in.global_mask) |-> ##[1:2] !cpu_irq_req) else $error("irq stays");
  // Margin covers the two synchroniser flops and the output register
  pin_follow_a: assert property ($stable(ext_int_pin_n)[*5] |-> pin_level_for_branch == ext_int_pin_n)
    else $error("pin level");
  // Main scenarios
  irq_c: cover property ($rose(cpu_irq_req));
  err_c: cover property (pslverr);
  fall_c: cover property ($fell(ext_int_pin_n));
endmodule

bind eil_top eil_top_asserts i_eil_top_asserts(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .ext_int_pin_n(ext_int_pin_n), .cpu_in(cpu_in),
  .cpu_irq_req(cpu_irq_req), .pin_level_for_branch(pin_level_for_branch));

// >>> testbench/eil_pin_src.sv
`timescale 1ns/1ps
// Interrupt source; idles high as with a pull-up
module eil_pin_src
(
  // Clock
  input wire logic pclk,
  // Pin
  output logic     pin_n
);
  initial pin_n = 1'b1;
  // Moves just after an edge, then holds for a prompt or slow span
  task automatic drive(input logic v, input int hold);
    @(posedge pclk);
    pin_n <= v;
    repeat (hold) @(posedge pclk);
  endtask
endmodule

// >>> testbench/eil_top_test.sv
`timescale 1ns/1ps
module eil_top_test;
  import eil_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, lvl, pin_n, err;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [15:0] vec;
  eil_cpu_t    cpu;
  int          bad_count, checks;
  eil_top i_eil_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_int_pin_n(pin_n), .cpu_in(cpu), .cpu_irq_req(irq), .pin_level_for_branch(lvl), .vector_addr(vec));
  eil_pin_src i_eil_pin_src(.pclk(pclk), .pin_n(pin_n));
  // Bus clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: bit %b want %b", $time, g, e);
    end
  endtask
  // One transfer; waits for ready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Response is taken 1 ns after the edge that starts the access cycle
    do
    begin
      #1;
      rdy = pready;
      q = prdata;
      err = pslverr;
      @(posedge pclk);
      n++;
    end
    while (rdy !== 1'b1 && n < 16);
    if (rdy !== 1'b1)
    begin
      bad_count++;
      $display("unexpected at %0t: no ready", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_reg(q, e);
  endtask
  task automatic pin(input logic v, input int h);
    i_eil_pin_src.drive(v, h);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog, over thirty times the expected run
  initial
  begin
    #40000;
    bad_count++;
    summarize;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cpu} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    rd(12'h008, 32'h1);
    chk_reg({16'h0, vec}, 32'h0000FFFA);
    rd(12'h00C, 32'h0);
    chk_bit(err, 1'b1);
    $display("reset test done");
    pin(1'b0, 2);
    pin(1'b1, 6);
    chk_bit(irq, 1'b1);
    rd(12'h000, 32'h8);
    apb(1'b1, 12'h000, 32'h4);
    rd(12'h000, 32'h0);
    pin(1'b0, 6);
    rd(12'h008, 32'h0);
    cpu.vec_fetch <= 1'b1;
    @(posedge pclk);
    cpu.vec_fetch <= 1'b0;
    rd(12'h000, 32'h0);
    chk_bit(irq, 1'b0);
    pin(1'b1, 6);
    $display("edge test done");
    apb(1'b1, 12'h000, 32'h2);
    pin(1'b0, 2);
    pin(1'b1, 6);
    chk_bit(irq, 1'b0);
    rd(12'h000, 32'hA);
    apb(1'b1, 12'h000, 32'h0);
    repeat (3) @(posedge pclk);
    chk_bit(irq, 1'b1);
    cpu.global_mask <= 1'b1;
    repeat (3) @(posedge pclk);
    chk_bit(irq, 1'b0);
    cpu.global_mask <= 1'b0;
    apb(1'b1, 12'h000, 32'h4);
    pin(1'b0, 2);
    pin(1'b1, 6);
    rd(12'h000, 32'h8);
    $display("mask test done");
    cpu.break_state <= 1'b1;
    apb(1'b1, 12'h000, 32'h4);
    rd(12'h000, 32'h8);
    cpu.break_clear_enable <= 1'b1;
    apb(1'b1, 12'h000, 32'h4);
    cpu.break_state <= 1'b0;
    rd(12'h000, 32'h0);
    $display("break test done");
    apb(1'b1, 12'h000, 32'h1);
    pin(1'b0, 6);
    apb(1'b1, 12'h000, 32'h7);
    rd(12'h000, 32'hB);
    pin(1'b1, 6);
    rd(12'h000, 32'h3);
    pin(1'b0, 6);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    $display("level test done");
    summarize;
  end
endmodule
